//--- tap_regs.svh
// Constants for the boundary-scan test access port: codes, widths, reset values.
`ifndef TAP_REGS_SVH
`define TAP_REGS_SVH

`define IR_WIDTH         4
`define IR_EXTEST        4'h0
`define IR_INTEST        4'h1
`define IR_SAMPLE        4'h2
`define IR_ABORT         4'h8
`define IR_DP_ACCESS     4'hA
`define IR_AP_ACCESS     4'hB
`define IR_IDCODE        4'hE
`define IR_BYPASS        4'hF
`define IR_CAPTURE_VAL   4'h1
`define ID_WIDTH         32
`define ID_VALUE         32'h1234_5001
`define BSR_WIDTH        8
`define TLR_TMS_COUNT    3'h5

`endif

//--- tap_pkg.sv
// Types shared by the test access port design files.
package tap_pkg;

  // Controller states of the boundary-scan state machine.
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
    ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
    ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } tap_state_t;

  // Data chain selected by the current instruction.
  typedef enum logic [1:0] {
    SEL_BYPASS, SEL_IDCODE, SEL_BSR, SEL_CORE
  } chain_sel_t;

  // Test pin bundle, raw or after synchronisation.
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtag_pins_t;

  // Test data output pin as data plus enable.
  typedef struct packed {
    logic tdo;
    logic tdo_oe;
  } tdo_pin_t;

endpackage : tap_pkg

//--- pin_sync.sv
// Three-stage synchroniser with agreement filter for the test pins.
`timescale 1ns/10ps
module pin_sync (
  // Clock and reset.
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Raw pins and the filtered result.
  input  wire tap_pkg::jtag_pins_t pins_in,
  output tap_pkg::jtag_pins_t    pins_out
);
  import tap_pkg::*;

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    jtag_pins_t s1;   // First stage, read only by the second.
    jtag_pins_t s2;   // Second stage.
    jtag_pins_t s3;   // Third stage.
    jtag_pins_t out;  // Filtered value.
  } sync_state_t;

  sync_state_t st_reg;  // Registered state.
  sync_state_t st_next; // Next state.

  // Shift the stages; a bit changes only when stages two and three agree.
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pins_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    for (int i = 0; i < $bits(jtag_pins_t); i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.out[i] = st_reg.s2[i];
      end
    end
  end

  // Reset every stage to the idle pin levels: all lines rest at their pull-up level.
  // A high clock here matches the controller's edge detector, so no edge follows reset.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= 16'hFFFF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pins_out = st_reg.out;

endmodule : pin_sync

//--- tap_ctrl.sv
// Test access port controller with instruction decode and output multiplexer.
//
// Summary of operation
// - Bits enter on data input, leave output.
// - State machine follows boundary-scan standard.
// - Four-bit instruction chain, standard plus debug codes.
// - Output mux picks core or own chain.
// - Own controller decodes all codes, drives select.
// - State moves only on reset, sampled mode.
// - Instruction chain plus data chains with updates.
// - State decides capture, shift, update, chain type.
// - Held instruction selects the accessed data chain.
// - External/internal test use bypass; boundary untouched.
// - Unimplemented codes behave exactly like bypass.
// - Test reset forces reset state, loads identity.
// - Five high mode cycles reach reset state.
// - Output idle when not shifting, falls change.
// - Sample on rise; stopped clock keeps state.
`timescale 1ns/10ps
`include "tap_regs.svh"
module tap_ctrl (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // Test pins from the tester.
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  input  wire logic               trst_n,
  // Core debug controller serial output.
  input  wire logic               core_tdo,
  // Test data output pin.
  output tap_pkg::tdo_pin_t       tdo_pin,
  // Core debug select, boundary update and test mode outputs.
  output logic                    core_sel,
  output logic [`BSR_WIDTH-1:0]   bsr_update,
  output logic                    test_mode,
  // Boundary pins observed during capture.
  input  wire logic [`BSR_WIDTH-1:0] bsr_pins
);
  import tap_pkg::*;

  // All checks below run on the system clock and sleep through system reset.
  default clocking cb_sys @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // ********************************************
  // Instruction decode
  // ********************************************
  // Map an instruction to its data chain; unknown codes fall to bypass.
  function automatic chain_sel_t decode_chain(input logic [`IR_WIDTH-1:0] ir);
    case (ir)
      `IR_IDCODE:                           decode_chain = SEL_IDCODE;
      `IR_SAMPLE:                           decode_chain = SEL_BSR;
      `IR_ABORT, `IR_DP_ACCESS, `IR_AP_ACCESS: decode_chain = SEL_CORE;
      `IR_EXTEST, `IR_INTEST:               decode_chain = SEL_BYPASS;
      default:                              decode_chain = SEL_BYPASS;
    endcase
  endfunction : decode_chain

  // Instructions that drive held boundary data onto the pins.
  function automatic logic is_test_instr(input logic [`IR_WIDTH-1:0] ir);
    is_test_instr = (ir == `IR_EXTEST) || (ir == `IR_INTEST);
  endfunction : is_test_instr

  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    tap_state_t              tap;       // Controller state.
    logic                    tck_d;     // Previous filtered test clock.
    logic [`IR_WIDTH-1:0]    ir_shift;  // Instruction shift chain.
    logic [`IR_WIDTH-1:0]    ir;        // Instruction update register.
    logic                    byp;       // Bypass bit.
    logic [`ID_WIDTH-1:0]    id_shift;  // Identity chain.
    logic [`BSR_WIDTH-1:0]   bsr_shift; // Boundary chain.
    logic [`BSR_WIDTH-1:0]   bsr_upd;   // Boundary update register.
    logic                    tdo;       // Output data, changes on falling edge.
    logic                    tdo_oe;    // Output enable.
    logic                    core_sel;  // Core debug select, driven out on core_sel.
    logic                    test_mode; // External or internal test active.
  } ctrl_state_t;

  ctrl_state_t st_reg;  // Registered state.
  ctrl_state_t st_next; // Next state.

  jtag_pins_t pins_raw;  // Raw pin bundle.
  jtag_pins_t pins;      // Synchronised pins.
  logic       core_tdo_q; // Core output, passed straight through with no register.

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

  // The tester clock is asynchronous, so every pin passes the filter.
  pin_sync u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  // Core output comes from logic on the same clock; no sync needed.
  assign core_tdo_q = core_tdo;

  logic       tck_rise;   // Rising test clock edge.
  logic       tck_fall;   // Falling test clock edge.
  chain_sel_t sel;        // Chain chosen by held instruction.
  logic       serial_out; // Chain end bit.

  assign tck_rise = pins.tck & ~st_reg.tck_d;
  assign tck_fall = ~pins.tck & st_reg.tck_d;
  assign sel      = decode_chain(st_reg.ir);

  // Select the chain end that feeds the output.
  always_comb begin
    serial_out = st_reg.byp;
    if (st_reg.tap == ST_SHIFT_IR) begin
      serial_out = st_reg.ir_shift[0];
    end else begin
      case (sel)
        SEL_IDCODE: serial_out = st_reg.id_shift[0];
        SEL_BSR:    serial_out = st_reg.bsr_shift[0];
        SEL_CORE:   serial_out = core_tdo_q;
        default:    serial_out = st_reg.byp;
      endcase
    end
  end

  // ********************************************
  // Next state
  // ********************************************
  // State moves only on a filtered rising edge or test reset; output on falling.
  always_comb begin
    st_next       = st_reg;
    st_next.tck_d = pins.tck;
    if (!pins.trst_n) begin
      st_next.tap = ST_RESET;
      st_next.ir  = `IR_IDCODE;
      st_next.tdo_oe = 1'b0;
    end else if (tck_rise) begin
      // Chain actions in the current state, then state transition.
      case (st_reg.tap)
        ST_CAP_IR:   st_next.ir_shift = `IR_CAPTURE_VAL;
        ST_SHIFT_IR: st_next.ir_shift = {pins.tdi, st_reg.ir_shift[`IR_WIDTH-1:1]};
        ST_UPD_IR:   st_next.ir = st_reg.ir_shift;
        ST_CAP_DR: begin
          case (sel)
            SEL_IDCODE: st_next.id_shift = `ID_VALUE;
            SEL_BSR:    st_next.bsr_shift = bsr_pins;
            SEL_BYPASS: st_next.byp = 1'b0;
            default:    st_next.byp = st_reg.byp;
          endcase
        end
        ST_SHIFT_DR: begin
          case (sel)
            SEL_IDCODE: st_next.id_shift = {pins.tdi, st_reg.id_shift[`ID_WIDTH-1:1]};
            SEL_BSR:    st_next.bsr_shift = {pins.tdi, st_reg.bsr_shift[`BSR_WIDTH-1:1]};
            SEL_BYPASS: st_next.byp = pins.tdi;
            default:    st_next.byp = st_reg.byp;
          endcase
        end
        ST_UPD_DR: begin
          // Test instructions decode to bypass, so held data stays put.
          if (sel == SEL_BSR) begin
            st_next.bsr_upd = st_reg.bsr_shift;
          end
        end
        default: st_next.tap = st_reg.tap;
      endcase
      case (st_reg.tap)
        ST_RESET:    st_next.tap = pins.tms ? ST_RESET    : ST_IDLE;
        ST_IDLE:     st_next.tap = pins.tms ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_DR:   st_next.tap = pins.tms ? ST_SEL_IR   : ST_CAP_DR;
        ST_CAP_DR:   st_next.tap = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR: st_next.tap = pins.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR: st_next.tap = pins.tms ? ST_UPD_DR   : ST_PAUSE_DR;
        ST_PAUSE_DR: st_next.tap = pins.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR: st_next.tap = pins.tms ? ST_UPD_DR   : ST_SHIFT_DR;
        ST_UPD_DR:   st_next.tap = pins.tms ? ST_SEL_DR   : ST_IDLE;
        ST_SEL_IR:   st_next.tap = pins.tms ? ST_RESET    : ST_CAP_IR;
        ST_CAP_IR:   st_next.tap = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR: st_next.tap = pins.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR: st_next.tap = pins.tms ? ST_UPD_IR   : ST_PAUSE_IR;
        ST_PAUSE_IR: st_next.tap = pins.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR: st_next.tap = pins.tms ? ST_UPD_IR   : ST_SHIFT_IR;
        ST_UPD_IR:   st_next.tap = pins.tms ? ST_SEL_DR   : ST_IDLE;
        default:     st_next.tap = ST_RESET;
      endcase
      if (st_next.tap == ST_RESET) begin
        st_next.ir = `IR_IDCODE;
      end
    end else if (tck_fall) begin
      // Drive only while shifting; otherwise release the pin.
      st_next.tdo_oe = (st_reg.tap == ST_SHIFT_DR) || (st_reg.tap == ST_SHIFT_IR);
      st_next.tdo    = serial_out;
    end
    st_next.core_sel  = (sel == SEL_CORE) && (st_next.tap != ST_SHIFT_IR);
    st_next.test_mode = is_test_instr(st_reg.ir);
  end

  // Registers; system reset forces the reset state and identity code.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg     <= '0;
      st_reg.tap <= ST_RESET;
      st_reg.ir  <= `IR_IDCODE;
      // The filtered clock leaves reset high; a low here would fake a rising edge.
      st_reg.tck_d <= 1'h1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tdo_pin    = '{tdo: st_reg.tdo, tdo_oe: st_reg.tdo_oe};
  assign core_sel   = st_reg.core_sel;
  assign bsr_update = st_reg.bsr_upd;
  assign test_mode  = st_reg.test_mode;

  // ********************************************
  // Assertions
  // ********************************************
  logic [2:0] tms_hi_cnt; // Rising edges seen with mode select high.
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !pins.trst_n || (tck_rise && !pins.tms)) begin
      tms_hi_cnt <= 3'h0;
    end else if (tck_rise && tms_hi_cnt != `TLR_TMS_COUNT) begin
      tms_hi_cnt <= tms_hi_cnt + 3'h1;
    end
  end

  property p_five_tms;
    tms_hi_cnt == `TLR_TMS_COUNT |-> st_reg.tap == ST_RESET;
  endproperty
  a_five_tms: assert property (p_five_tms) else $error("Mode reset missed.");

  property p_trst;
    !pins.trst_n |=> st_reg.tap == ST_RESET && st_reg.ir == `IR_IDCODE;
  endproperty
  a_trst: assert property (p_trst) else $error("Test reset missed.");

  // The first state after system reset must still be the reset state.
  property p_por;
    $fell(sys_rst) |=> st_reg.tap == ST_RESET && st_reg.ir == `IR_IDCODE;
  endproperty
  a_por: assert property (p_por) else $error("System reset missed reset state.");

  property p_hold;
    !tck_rise && pins.trst_n |=> $stable(st_reg.tap);
  endproperty
  a_hold: assert property (p_hold) else $error("State moved without a clock edge.");

  property p_oe_idle;
    tck_fall && st_reg.tap == ST_IDLE |=> !tdo_pin.tdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("Output driven while idle.");

  property p_oe_shift;
    tck_fall && pins.trst_n && st_reg.tap == ST_SHIFT_DR |=> tdo_pin.tdo_oe;
  endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("Output idle while shifting.");

  property p_tdo_stable;
    !$past(tck_fall) && $past(pins.trst_n) |-> $stable(tdo_pin.tdo);
  endproperty
  a_tdo_stable: assert property (p_tdo_stable) else $error("Output moved early.");

  property p_ir_cap;
    tck_rise && pins.trst_n && st_reg.tap == ST_CAP_IR
      |=> st_reg.ir_shift == `IR_CAPTURE_VAL;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("Wrong instruction capture.");

  property p_ir_upd;
    tck_rise && pins.trst_n && st_reg.tap == ST_UPD_IR
      |=> st_reg.ir == $past(st_reg.ir_shift);
  endproperty
  a_ir_upd: assert property (p_ir_upd) else $error("Instruction not updated.");

  property p_id_cap;
    tck_rise && pins.trst_n && st_reg.tap == ST_CAP_DR && sel == SEL_IDCODE
      |=> st_reg.id_shift == `ID_VALUE;
  endproperty
  a_id_cap: assert property (p_id_cap) else $error("Identity not captured.");

  property p_core_sel;
    st_reg.tap == ST_SHIFT_DR && sel == SEL_CORE |=> core_sel;
  endproperty
  a_core_sel: assert property (p_core_sel) else $error("Core select missing.");

  property p_unknown;
    st_reg.ir == 4'h5 |-> sel == SEL_BYPASS;
  endproperty
  a_unknown: assert property (p_unknown) else $error("Unknown code not bypass.");

  property p_byp_cap;
    tck_rise && pins.trst_n && st_reg.tap == ST_CAP_DR && sel == SEL_BYPASS |=> !st_reg.byp;
  endproperty
  a_byp_cap: assert property (p_byp_cap) else $error("Bypass did not capture zero.");

  property p_ext_hold;
    is_test_instr(st_reg.ir) |=> $stable(st_reg.bsr_upd);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("Held boundary data moved.");

  // Main scenarios that the bench is expected to reach.
  c_shift_ir: cover property (@(posedge sys_clk) st_reg.tap == ST_SHIFT_IR);
  c_core:     cover property (@(posedge sys_clk) core_sel && tdo_pin.tdo_oe);
  c_upd_bsr:  cover property (@(posedge sys_clk) st_reg.tap == ST_UPD_DR && sel == SEL_BSR);
  c_tms_rst:  cover property (@(posedge sys_clk) tms_hi_cnt == `TLR_TMS_COUNT);

endmodule : tap_ctrl

//--- tap_tester.sv
// Behavioural boundary-scan tester that drives the test pins.
`timescale 1ns/10ps
module tap_tester (
  // Bench clock that times the pins.
  input  wire logic sys_clk,
  // Test pins towards the device.
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n,
  // Resolved data line and core select.
  input  wire logic tdo_line,
  input  wire logic core_sel
);
  // ****************************************
  // Pin timing
  // ****************************************
  localparam int HALF = 16; // Half of the 160 ns test clock in 5 ns cycles.
  logic last_sel;           // Core select seen at the last sample.
  logic sel_all;            // High if core select stood on every shifted bit.

  // Pins rest at their pull-up level; the clock stands high between frames.
  initial begin
    tck = 1'h1;
    tms = 1'h1;
    tdi = 1'h1;
    trst_n = 1'h1;
    last_sel = 1'h0;
    sel_all = 1'h0;
  end

  // One clock: change on the fall, sample late in the low phase so the output has settled.
  task automatic tick(input logic m, input logic d, output logic q);
    @(negedge sys_clk);
    tck = 1'h0;
    tms = m;
    tdi = d;
    repeat (HALF) @(negedge sys_clk);
    q = tdo_line;
    last_sel = core_sel;
    tck = 1'h1;
    repeat (HALF) @(negedge sys_clk);
  endtask : tick

  // Sets the test reset pin; the tester is the only driver of its pins.
  task automatic set_reset(input logic level);
    trst_n = level;
  endtask : set_reset

  // Full scan from idle back to idle, least significant bit first.
  task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    sel_all = 1'h1;
    tick(1'h1, 1'h1, q);
    if (is_ir) begin
      tick(1'h1, 1'h1, q);
    end
    tick(1'h0, 1'h1, q);
    tick(1'h0, 1'h1, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
      sel_all = sel_all & last_sel;
    end
    tick(1'h1, 1'h1, q);
    tick(1'h0, 1'h1, q);
  endtask : scan
endmodule : tap_tester

//--- jtag_tap_with_tdo_mux_tb.sv
// Self-checking bench for the test access port controller.
`timescale 1ns/10ps
`include "tap_regs.svh"
module jtag_tap_with_tdo_mux_tb;
  import tap_pkg::*;
  logic                  sys_clk = 1'h0;  // 200 MHz bench clock.
  logic                  sys_rst = 1'h1;  // Held for 8 cycles.
  logic                  core_tdo = 1'h0; // Stand-in for the core debug output.
  logic [`BSR_WIDTH-1:0] bsr_pins = 8'h00;
  logic                  tck, tms, tdi, trst_n;
  tdo_pin_t              tdo_pin;
  logic                  core_sel;
  logic [`BSR_WIDTH-1:0] bsr_update;
  logic                  test_mode;
  wire logic             tdo_line;
  int                    miscompares = 0;
  int                    n_checks = 0;
  logic [31:0]           dout;

  // The line has a pull-up, so a released output reads high.
  assign tdo_line = tdo_pin.tdo_oe ? tdo_pin.tdo : 1'h1;
  always #2.5 sys_clk = ~sys_clk;

  tap_ctrl u_tap_ctrl (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .tck        (tck),
    .tms        (tms),
    .tdi        (tdi),
    .trst_n     (trst_n),
    .core_tdo   (core_tdo),
    .tdo_pin    (tdo_pin),
    .core_sel   (core_sel),
    .bsr_update (bsr_update),
    .test_mode  (test_mode),
    .bsr_pins   (bsr_pins)
  );

  tap_tester u_tap_tester (
    .sys_clk  (sys_clk),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .trst_n   (trst_n),
    .tdo_line (tdo_line),
    .core_sel (core_sel)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Loads an instruction; the captured pattern must come out first.
  task automatic load_ir(input logic [3:0] code);
    logic [31:0] cap;
    u_tap_tester.scan(1'h1, `IR_WIDTH, {28'h0, code}, cap);
    check("ir capture", cap, {28'h0, `IR_CAPTURE_VAL});
  endtask : load_ir

  // From reset state: step to idle, then read the identity chain.
  task automatic read_id(input string name);
    logic q;
    u_tap_tester.tick(1'h0, 1'h1, q);
    u_tap_tester.scan(1'h0, `ID_WIDTH, 32'hFFFF_FFFF, dout);
    check(name, dout, `ID_VALUE);
  endtask : read_id

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_state();
    check("tdo_oe", 32'(tdo_pin.tdo_oe), 32'h0);
    check("core_sel", 32'(core_sel), 32'h0);
    read_id("id after power-on");
    check("tdo_oe idle", 32'(tdo_pin.tdo_oe), 32'h0);
    // The identity instruction loaded by hand must give the same chain.
    load_ir(`IR_IDCODE);
    u_tap_tester.scan(1'h0, `ID_WIDTH, 32'h0, dout);
    check("id by instruction", dout, `ID_VALUE);
  endtask : t_reset_state

  // Unused codes and bypass itself give a one-bit path that captures zero.
  task automatic t_bypass();
    logic [3:0] codes [9] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hC, 4'hD, `IR_BYPASS};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      u_tap_tester.scan(1'h0, 8, 32'hB4, dout);
      check("bypass path", dout, 32'h68);
      check("core select off", 32'(u_tap_tester.sel_all), 32'h0);
    end
  endtask : t_bypass

  task automatic t_sample();
    bsr_pins = 8'hA5;
    load_ir(`IR_SAMPLE);
    // A long stop of the test clock must not lose the instruction.
    repeat (300) @(negedge sys_clk);
    u_tap_tester.scan(1'h0, `BSR_WIDTH, 32'h3C, dout);
    check("boundary capture", dout, 32'hA5);
    check("boundary update", 32'(bsr_update), 32'h3C);
    check("test mode", 32'(test_mode), 32'h0);
  endtask : t_sample

  // Pin test modes must leave the update register frozen.
  task automatic t_hold_tests();
    logic [3:0] codes [2] = '{`IR_EXTEST, `IR_INTEST};
    foreach (codes[i]) begin
      load_ir(codes[i]);
      check("test mode", 32'(test_mode), 32'h1);
      u_tap_tester.scan(1'h0, 8, 32'h5A, dout);
      check("held update", 32'(bsr_update), 32'h3C);
      check("held path", dout, 32'hB4);
    end
  endtask : t_hold_tests

  task automatic t_core();
    logic [3:0] codes [3] = '{`IR_ABORT, `IR_DP_ACCESS, `IR_AP_ACCESS};
    foreach (codes[i]) begin
      core_tdo = codes[i][0] ^ codes[i][1];
      load_ir(codes[i]);
      u_tap_tester.scan(1'h0, 8, 32'h00, dout);
      check("core path", dout, {24'h0, {8{core_tdo}}});
      check("core select", 32'(u_tap_tester.sel_all), 32'h1);
    end
    core_tdo = 1'h0;
  endtask : t_core

  // Five high mode cycles from the data shift state, which needs all five to reach reset.
  task automatic t_tms_reset();
    logic q;
    load_ir(`IR_BYPASS);
    u_tap_tester.tick(1'h1, 1'h1, q);
    u_tap_tester.tick(1'h0, 1'h1, q);
    u_tap_tester.tick(1'h0, 1'h1, q);
    repeat (5) u_tap_tester.tick(1'h1, 1'h1, q);
    read_id("id after mode reset");
  endtask : t_tms_reset

  // Clocking during the test reset would leave the reset state if it were not held.
  task automatic t_trst();
    logic q;
    load_ir(`IR_BYPASS);
    u_tap_tester.set_reset(1'h0);
    repeat (8) @(negedge sys_clk);
    u_tap_tester.tick(1'h0, 1'h1, q);
    u_tap_tester.tick(1'h1, 1'h1, q);
    u_tap_tester.set_reset(1'h1);
    repeat (8) @(negedge sys_clk);
    read_id("id after test reset");
  endtask : t_trst

  // Main sequence.
  initial begin
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'h0;
    repeat (4) @(negedge sys_clk);
    t_reset_state();
    t_bypass();
    t_sample();
    t_hold_tests();
    t_core();
    t_tms_reset();
    t_trst();
    tally_and_finish();
  end

  // A hang counts as a mismatch and ends the run.
  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  end
endmodule : jtag_tap_with_tdo_mux_tb
